// File: clk_out_defines.svh
// Contract
// - Cleared enable bit holds both pins of that pair high impedance; enables reset to zero.
// - Set enable bit drives the pair in the style chosen by its style field.
// - Pair three polarity bit, bit 3: clear normal, set inverted.
// - Pair three style: 000 off, 001/010/011/100 driven, 101-111 reserved; resets 001.
// - Pairs zero to two style: 011 and 101-111 reserved; resets 001.
// - Pair three single-ended, phase bit clear: both pins opposite phase.
// - Pair three single-ended, phase bit set: both pins in phase.
// - Reserved bits are written zero; their read value is not defined.
`ifndef CLK_OUT_DEFINES_SVH
`define CLK_OUT_DEFINES_SVH

// ****************************************
// Register indices (byte address is index times four)
// ****************************************
`define CO_IDX_EN 8'h39
`define CO_IDX_POL 8'h3A
`define CO_IDX_RSV_A 8'h3B
`define CO_IDX_RSV_B 8'h3C
`define CO_IDX_STY32 8'h3D
`define CO_IDX_STY10 8'h3E

// ****************************************
// Field positions
// ****************************************
`define CO_EN_MSB 3
`define CO_POL_BIT 3
`define CO_HI_STY_LSB 5
`define CO_SE_BIT 4
`define CO_LO_STY_LSB 1

// ****************************************
// Reset values and writable masks
// ****************************************
`define CO_EN_RST 8'h00
`define CO_POL_RST 8'h00
`define CO_STY_RST 8'h22
`define CO_EN_MASK 8'h0F
`define CO_POL_MASK 8'h08
`define CO_STY32_MASK 8'hFE
`define CO_STY10_MASK 8'hEE

`endif

// File: clk_out_pkg.sv
package clk_out_pkg;

	typedef enum logic [2:0] {
		STYLE_HIZ = 3'h0,
		STYLE_LVPECL = 3'h1,
		STYLE_LVDS = 3'h2,
		STYLE_LVCMOS = 3'h3,
		STYLE_HCSL = 3'h4
	} drv_style_t;

	typedef struct packed {
		logic en;
		logic [2:0] style;
		logic invert;
		logic se_phase;
	} pair_cfg_t;

	typedef struct packed {
		logic true_o;
		logic comp_o;
		logic oe;
	} pin_t;

endpackage

// File: reg_byte.sv
`timescale 1ns/1ps
`default_nettype none
module reg_byte #(
	parameter logic [7:0] RST = 8'h00,
	parameter logic [7:0] MASK = 8'hFF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic we,
	input wire logic [7:0] wdata,
	output var logic [7:0] q
);
	// Reserved positions are never stored, so they always read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RST;
		end else if (we) begin
			q <= wdata & MASK;
		end
	end
endmodule // reg_byte
`default_nettype wire

// File: pair_driver.sv
`timescale 1ns/1ps
`default_nettype none
module pair_driver
	import clk_out_pkg::*;
#(
	parameter bit HAS_LVCMOS = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire pair_cfg_t cfg,
	input wire logic src,
	output var pin_t pins,
	output var drv_style_t style
);
	logic active;
	logic lvl;

	always_comb begin
		active = 1'b0;
		case (cfg.style)
			STYLE_LVPECL, STYLE_LVDS, STYLE_HCSL: active = cfg.en;
			STYLE_LVCMOS: active = cfg.en & HAS_LVCMOS;
			default: active = 1'b0;
		endcase
	end

	assign lvl = src ^ cfg.invert;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins <= '0;
			style <= STYLE_HIZ;
		end else if (active) begin
			pins.oe <= 1'b1;
			pins.true_o <= lvl;
			// In-phase only for single-ended style
			if (cfg.style == STYLE_LVCMOS && cfg.se_phase) begin
				pins.comp_o <= lvl;
			end else begin
				pins.comp_o <= ~lvl;
			end
			style <= drv_style_t'(cfg.style);
		end else begin
			pins <= '0;
			style <= STYLE_HIZ;
		end
	end
endmodule // pair_driver
`default_nettype wire

// File: clock_output_driver_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "clk_out_defines.svh"
module clock_output_driver_config
	import clk_out_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	input wire logic [3:0] src_clk,
	output var pin_t [3:0] pins,
	output var drv_style_t [3:0] pair_style
);

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic [7:0] reg_index(input logic [11:0] a);
		reg_index = a[9:2];
	endfunction

	function automatic logic addr_ok(input logic [11:0] a);
		logic [7:0] i;
		i = reg_index(a);
		addr_ok = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
			(i >= `CO_IDX_EN) && (i <= `CO_IDX_STY10);
	endfunction

	logic setup;
	logic access;
	logic wr_ok;
	logic [7:0] idx;
	logic [7:0] en_reg_q;
	logic [7:0] pol_reg_q;
	logic [7:0] sty32_q;
	logic [7:0] sty10_q;
	logic [7:0] rd_byte;
	logic pready_d;
	logic pslverr_d;
	pair_cfg_t [3:0] cfg;

	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign idx = reg_index(paddr);
	// Byte lane 0 carries every register; other lanes are ignored
	assign wr_ok = access & pwrite & ~pslverr & pstrb[0];

	// ****************************************
	// APB answer
	// ****************************************
	// Registered answer gives zero wait states: ready is high for the access cycle
	always_comb begin
		pready_d = setup;
		pslverr_d = setup & ~addr_ok(paddr);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= pready_d;
			pslverr <= pslverr_d;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		case (idx)
			`CO_IDX_EN: rd_byte = en_reg_q;
			`CO_IDX_POL: rd_byte = pol_reg_q;
			`CO_IDX_STY32: rd_byte = sty32_q;
			`CO_IDX_STY10: rd_byte = sty10_q;
			default: rd_byte = 8'h00;
		endcase
	end

	// Read data is sampled in the setup cycle; no register changes before the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup && !pwrite && addr_ok(paddr)) begin
			prdata <= {24'h000000, rd_byte};
		end else begin
			prdata <= 32'h00000000;
		end
	end

	// ****************************************
	// Register bank
	// ****************************************
	// Reserved bits are masked off, so writing them has no effect
	reg_byte #(.RST(`CO_EN_RST), .MASK(`CO_EN_MASK)) u_en (
		.pclk(pclk),
		.presetn(presetn),
		.we(wr_ok && idx == `CO_IDX_EN),
		.wdata(pwdata[7:0]),
		.q(en_reg_q)
	);

	reg_byte #(.RST(`CO_POL_RST), .MASK(`CO_POL_MASK)) u_pol (
		.pclk(pclk),
		.presetn(presetn),
		.we(wr_ok && idx == `CO_IDX_POL),
		.wdata(pwdata[7:0]),
		.q(pol_reg_q)
	);

	reg_byte #(.RST(`CO_STY_RST), .MASK(`CO_STY32_MASK)) u_sty32 (
		.pclk(pclk),
		.presetn(presetn),
		.we(wr_ok && idx == `CO_IDX_STY32),
		.wdata(pwdata[7:0]),
		.q(sty32_q)
	);

	reg_byte #(.RST(`CO_STY_RST), .MASK(`CO_STY10_MASK)) u_sty10 (
		.pclk(pclk),
		.presetn(presetn),
		.we(wr_ok && idx == `CO_IDX_STY10),
		.wdata(pwdata[7:0]),
		.q(sty10_q)
	);

	// ****************************************
	// Per-pair configuration
	// ****************************************
	// Phase bit is passed as written; pair_driver ignores it in differential styles and uses it only in single-ended style
	always_comb begin
		cfg[3].en = en_reg_q[3];
		cfg[3].style = sty32_q[`CO_HI_STY_LSB +: 3];
		cfg[3].invert = pol_reg_q[`CO_POL_BIT];
		cfg[3].se_phase = sty32_q[`CO_SE_BIT];
		cfg[2].en = en_reg_q[2];
		cfg[2].style = sty32_q[`CO_LO_STY_LSB +: 3];
		cfg[2].invert = 1'b0;
		cfg[2].se_phase = 1'b0;
		cfg[1].en = en_reg_q[1];
		cfg[1].style = sty10_q[`CO_HI_STY_LSB +: 3];
		cfg[1].invert = 1'b0;
		cfg[1].se_phase = 1'b0;
		cfg[0].en = en_reg_q[0];
		cfg[0].style = sty10_q[`CO_LO_STY_LSB +: 3];
		cfg[0].invert = 1'b0;
		cfg[0].se_phase = 1'b0;
	end

	// ****************************************
	// Pair drivers
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pair
			pair_driver #(.HAS_LVCMOS(g == 3)) u_drv (
				.pclk(pclk),
				.presetn(presetn),
				.cfg(cfg[g]),
				.src(src_clk[g]),
				.pins(pins[g]),
				.style(pair_style[g])
			);
		end
	endgenerate

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	function automatic logic valid_code(input logic [2:0] s, input logic lv);
		valid_code = (s == 3'h1) || (s == 3'h2) || (s == 3'h4) || (lv && s == 3'h3);
	endfunction

	generate
		for (g = 0; g < 4; g++) begin : g_chk
			a_disabled_hiz: assert property (!cfg[g].en |=> !pins[g].oe && !pins[g].true_o)
				else $error("disabled pair not high impedance");
			a_enabled_drive: assert property (cfg[g].en && valid_code(cfg[g].style, g == 3)
				|=> pins[g].oe && pair_style[g] == $past(cfg[g].style))
				else $error("enabled pair not driven in its style");
			a_active_only: assert property (pins[g].oe
				|-> $past(cfg[g].en) && valid_code($past(cfg[g].style), g == 3))
				else $error("pair driven without valid enable and style");
		end
	endgenerate

	a_pair3_invert: assert property (pins[3].oe && $past(pins[3].oe) && $past(cfg[3].style) != 3'h3
		|-> pins[3].true_o == ($past(src_clk[3]) ^ $past(cfg[3].invert)))
		else $error("pair three polarity wrong");

	a_pair3_cmos: assert property (cfg[3].en && cfg[3].style == 3'h3
		|=> pins[3].oe && pair_style[3] == STYLE_LVCMOS)
		else $error("pair three single-ended style not driven");

	a_pair_rsvd: assert property (cfg[0].style == 3'h3 || cfg[0].style[2:1] == 2'h3 ||
		cfg[0].style == 3'h5 |=> !pins[0].oe)
		else $error("reserved code drove pair zero");

	a_se_opposite: assert property (cfg[3].en && cfg[3].style == 3'h3 && !cfg[3].se_phase
		|=> pins[3].comp_o != pins[3].true_o)
		else $error("single-ended pins not opposite");

	a_se_inphase: assert property (cfg[3].en && cfg[3].style == 3'h3 && cfg[3].se_phase
		|=> pins[3].comp_o == pins[3].true_o)
		else $error("single-ended pins not in phase");

	a_rsvd_read: assert property (setup && !pwrite && (idx == `CO_IDX_RSV_A || idx == `CO_IDX_RSV_B)
		|=> prdata == 32'h00000000)
		else $error("reserved register read nonzero");

	a_rsvd_bits: assert property (wr_ok && idx == `CO_IDX_EN |=> en_reg_q[7:4] == 4'h0 ##1
		!$past(cfg[0].en) || pins[0].oe || !valid_code($past(cfg[0].style), 1'b0))
		else $error("reserved enable bits stored");

	a_apb_ready: assert property (setup |=> pready ##1 !pready)
		else $error("slave ready not one access cycle");

	// ****************************************
	// Bus answer checks
	// ****************************************
	a_ready_setup: assert property (pready
		|-> $past(setup))
		else $error("ready without a preceding setup");

	a_err_ready: assert property (pslverr
		|-> pready)
		else $error("error flag outside access cycle");

	a_err_bad_addr: assert property (pslverr
		|-> !addr_ok($past(paddr)))
		else $error("error flag on a mapped address");

	a_err_good_addr: assert property (pready && !pslverr
		|-> addr_ok($past(paddr)))
		else $error("unmapped address answered without error");

	a_rdata_idle: assert property (!pready
		|-> prdata == 32'h00000000)
		else $error("read data outside access cycle");

	a_rdata_write: assert property (pready && $past(pwrite)
		|-> prdata == 32'h00000000)
		else $error("read data during a write");

	// Only the low byte carries a register; the rest must never leak
	a_rdata_upper: assert property (prdata[31:8] == 24'h000000)
		else $error("upper read data bits set");

	a_read_en: assert property (setup && !pwrite && idx == `CO_IDX_EN
		|=> prdata == {24'h000000, $past(en_reg_q)})
		else $error("enable register read wrong");

	a_read_pol: assert property (setup && !pwrite && idx == `CO_IDX_POL
		|=> prdata == {24'h000000, $past(pol_reg_q)})
		else $error("polarity register read wrong");

	a_read_sty32: assert property (setup && !pwrite && idx == `CO_IDX_STY32
		|=> prdata == {24'h000000, $past(sty32_q)})
		else $error("upper style register read wrong");

	a_read_sty10: assert property (setup && !pwrite && idx == `CO_IDX_STY10
		|=> prdata == {24'h000000, $past(sty10_q)})
		else $error("lower style register read wrong");

	// ****************************************
	// Register bank checks
	// ****************************************
	a_en_upper: assert property (en_reg_q[7:4] == 4'h0)
		else $error("enable register reserved bits set");

	a_pol_mask: assert property ((pol_reg_q & ~`CO_POL_MASK) == 8'h00)
		else $error("polarity register reserved bits set");

	a_sty32_mask: assert property (sty32_q[0] == 1'b0)
		else $error("upper style register reserved bit set");

	a_sty10_mask: assert property (sty10_q[4] == 1'b0 && sty10_q[0] == 1'b0)
		else $error("lower style register reserved bits set");

	a_en_write: assert property (wr_ok && idx == `CO_IDX_EN
		|=> en_reg_q == ($past(pwdata[7:0]) & `CO_EN_MASK))
		else $error("enable register write lost");

	a_pol_write: assert property (wr_ok && idx == `CO_IDX_POL
		|=> pol_reg_q == ($past(pwdata[7:0]) & `CO_POL_MASK))
		else $error("polarity register write lost");

	a_sty32_write: assert property (wr_ok && idx == `CO_IDX_STY32
		|=> sty32_q == ($past(pwdata[7:0]) & `CO_STY32_MASK))
		else $error("upper style register write lost");

	a_sty10_write: assert property (wr_ok && idx == `CO_IDX_STY10
		|=> sty10_q == ($past(pwdata[7:0]) & `CO_STY10_MASK))
		else $error("lower style register write lost");

	a_en_hold: assert property (!(wr_ok && idx == `CO_IDX_EN)
		|=> $stable(en_reg_q))
		else $error("enable register changed without a write");

	a_pol_hold: assert property (!(wr_ok && idx == `CO_IDX_POL)
		|=> $stable(pol_reg_q))
		else $error("polarity register changed without a write");

	a_sty32_hold: assert property (!(wr_ok && idx == `CO_IDX_STY32)
		|=> $stable(sty32_q))
		else $error("upper style register changed without a write");

	a_sty10_hold: assert property (!(wr_ok && idx == `CO_IDX_STY10)
		|=> $stable(sty10_q))
		else $error("lower style register changed without a write");

	// A write with lane 0 off is dropped silently rather than flagged
	a_no_strobe: assert property (access && pwrite && !pstrb[0]
		|=> $stable(en_reg_q) && $stable(pol_reg_q) && $stable(sty32_q) && $stable(sty10_q))
		else $error("write without low strobe changed a register");

	a_err_no_write: assert property (access && pslverr
		|=> $stable(en_reg_q) && $stable(pol_reg_q) && $stable(sty32_q) && $stable(sty10_q))
		else $error("refused write changed a register");

	// ****************************************
	// Pin checks
	// ****************************************
	generate
		for (g = 0; g < 4; g++) begin : g_pin_chk
			a_style_oe: assert property (pins[g].oe == (pair_style[g] != STYLE_HIZ))
				else $error("reported style disagrees with output enable");

			a_off_levels: assert property (!pins[g].oe
				|-> !pins[g].true_o && !pins[g].comp_o)
				else $error("disabled pair shows a level");

			a_diff_opposite: assert property (pins[g].oe && pair_style[g] != STYLE_LVCMOS
				|-> pins[g].comp_o != pins[g].true_o)
				else $error("differential pins not complementary");

			a_true_follows: assert property (pins[g].oe
				|-> pins[g].true_o == ($past(src_clk[g]) ^ $past(cfg[g].invert)))
				else $error("true pin does not follow its source");
		end
	endgenerate

	a_lo_no_cmos: assert property (pair_style[0] != STYLE_LVCMOS && pair_style[1] != STYLE_LVCMOS
		&& pair_style[2] != STYLE_LVCMOS)
		else $error("single-ended style on pairs zero to two");

	c_enable_pair3: cover property (wr_ok && idx == `CO_IDX_EN && pwdata[3] ##2 pins[3].oe);
	c_se_inphase: cover property (pins[3].oe && pair_style[3] == STYLE_LVCMOS && pins[3].comp_o == pins[3].true_o);
	c_bad_addr: cover property (access && pslverr);
	c_read_back: cover property (setup && !pwrite && idx == `CO_IDX_STY32 ##1 pready);
	c_disable_pair0: cover property (wr_ok && idx == `CO_IDX_EN && !pwdata[0] ##2 !pins[0].oe);

endmodule // clock_output_driver_config
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import clk_out_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, eflag;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, src_clk;
	pin_t [3:0] pins;
	drv_style_t [3:0] pair_style;
	int err_count, samples_checked;

	clock_output_driver_config u_clock_output_driver_config (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_clk(src_clk), .pins(pins), .pair_style(pair_style)
	);

	// ****************************************
	// Clock, reset and checking helpers
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Inserts one idle cycle first so psel is never assigned twice in one step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// Ready, read data and error are taken at the rising edge that ends the access
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			close_out();
		end else begin
			rd = prdata;
			eflag = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic perr);
		apb(1'b0, a, 32'h0, 4'hF);
		chk_reg(rd, exp);
		chk_reg({31'h0, eflag}, {31'h0, perr});
	endtask

	// Off pairs compare only oe and style; pin levels, held low, are not compared
	task automatic chk_pair(input int g, input logic en, input logic [2:0] c, input logic inv, input logic se);
		logic ok, t;
		int s;
		for (s = 0; s < 2; s++) begin
			src_clk <= {4{s[0]}};
			repeat (3) @(posedge pclk);
			ok = en && (c == 3'h1 || c == 3'h2 || c == 3'h4 || (g == 3 && c == 3'h3));
			t = s[0] ^ inv;
			chk_pin({pins[g].oe, pair_style[g], ok & pins[g].true_o, ok & pins[g].comp_o},
				{ok, ok ? c : 3'h0, ok & t, ok & ((g == 3 && c == 3'h3 && se) ? t : ~t)});
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset();
		int g;
		rd_chk(12'hE4, 32'h00, 1'b0);
		rd_chk(12'hE8, 32'h00, 1'b0);
		rd_chk(12'hF4, 32'h22, 1'b0);
		rd_chk(12'hF8, 32'h22, 1'b0);
		for (g = 0; g < 4; g++) chk_pair(g, 1'b0, 3'h1, 1'b0, 1'b0);
		$display("test reset done");
	endtask

	task automatic test_styles();
		int c, g;
		logic [2:0] cc;
		apb(1'b1, 12'hE4, 32'h0F, 4'hF);
		for (c = 0; c < 8; c++) begin
			cc = c[2:0];
			apb(1'b1, 12'hF4, {24'h0, cc, 1'b0, cc, 1'b0}, 4'hF);
			apb(1'b1, 12'hF8, {24'h0, cc, 1'b0, cc, 1'b0}, 4'hF);
			rd_chk(12'hF8, {24'h0, cc, 1'b0, cc, 1'b0}, 1'b0);
			for (g = 0; g < 4; g++) chk_pair(g, 1'b1, cc, 1'b0, 1'b0);
		end
		$display("test styles done");
	endtask

	// Phase bit is only set with the single-ended style, as software must
	task automatic test_pair3();
		int k;
		for (k = 0; k < 4; k++) begin
			apb(1'b1, 12'hE8, {28'h0, k[1], 3'h0}, 4'hF);
			apb(1'b1, 12'hF4, {24'h0, 3'h3, k[0], 4'h2}, 4'hF);
			chk_pair(3, 1'b1, 3'h3, k[1], k[0]);
		end
		$display("test pair3 done");
	endtask

	task automatic test_disable();
		int g;
		apb(1'b1, 12'hF8, 32'h22, 4'hF);
		apb(1'b1, 12'hE4, 32'h02, 4'hF);
		for (g = 0; g < 3; g++) chk_pair(g, g == 1, 3'h1, 1'b0, 1'b0);
		apb(1'b1, 12'hE4, 32'h0F, 4'hE);
		rd_chk(12'hE4, 32'h02, 1'b0);
		apb(1'b1, 12'hE4, 32'hFF, 4'hF);
		rd_chk(12'hE4, 32'h0F, 1'b0);
		apb(1'b1, 12'hEC, 32'hFF, 4'hF);
		rd_chk(12'hEC, 32'h00, 1'b0);
		apb(1'b1, 12'h100, 32'h0F, 4'hF);
		chk_reg({31'h0, eflag}, 32'h1);
		rd_chk(12'h100, 32'h00, 1'b1);
		$display("test disable done");
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		src_clk = 4'h0;
		err_count = 0;
		samples_checked = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_styles();
		test_pair3();
		test_disable();
		close_out();
	end
endmodule // tb
`default_nettype wire
